// ==== ldic_bus_master.sv ====
`timescale 1ns/1ps
module ldic_bus_master
(
    // clock
    input  wire logic clk,
    // bus lines, sda open drain with a pull-up
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_low
);
    // half scl period in clk; the port wants at least 8
    localparam int HALF = 10;

    initial
    begin
        scl     = 1'b1;
        sda_low = 1'b0;
    end

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    // data moves 2 clk after the scl fall so it never changes while scl is high
    task automatic bit_cycle(input logic pull, output logic seen);
        wait_clk(2);
        sda_low = pull;
        wait_clk(HALF);
        scl = 1'b1;
        wait_clk(HALF);
        seen = sda_line;
        scl = 1'b0;
    endtask

    // serves as start and as repeated start
    task automatic start_cond();
        wait_clk(2);
        sda_low = 1'b0;
        wait_clk(HALF);
        scl = 1'b1;
        wait_clk(HALF);
        sda_low = 1'b1;
        wait_clk(HALF);
        scl = 1'b0;
    endtask

    task automatic stop_cond();
        wait_clk(2);
        sda_low = 1'b1;
        wait_clk(HALF);
        scl = 1'b1;
        wait_clk(HALF);
        sda_low = 1'b0;
        wait_clk(HALF);
    endtask

    task automatic send_byte(input logic [7:0] b, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_cycle(~b[i], s);
        bit_cycle(1'b0, s);
        ack = ~s;
    endtask

    task automatic recv_byte(input logic give_ack, output logic [7:0] b);
        logic s;
        for (int i = 7; i >= 0; i--)
        begin
            bit_cycle(1'b0, s);
            b[i] = s;
        end
        bit_cycle(give_ack, s);
    endtask
endmodule // ldic_bus_master

// ==== ldic_i2c_port.sv ====
// Operation
// - answer as bus slave at address 0x1B
// - command 011 loads all current levels
// - command 100 loads all PWM duties
// - command 001 writes one indexed register
// - command 010 writes and applies outputs
// - mask written by 001 waits for apply
// - command 000 applies pending outputs, no data
// - output mask at index 0x10, bit per channel
// - repeated start read drives selected byte
// - channel one duty at 0x08 reads back
// - duty 0x20 gives half duty cycle
// - mask bit 1 enables, bit0 is channel one
// - all registers clear at reset
`timescale 1ns/1ps
module ldic_i2c_port
(
    // clock and reset
    input  wire logic                                                  clk,
    input  wire logic                                                  rst_n,
    // serial bus pins
    input  wire logic                                                  scl_i,
    input  wire logic                                                  sda_i,
    output logic                                                       sda_o,
    output logic                                                       sda_oe_n,
    // channel outputs
    output logic [ldic_pkg::NUM_CH-1:0]                                chan_drive,
    output logic [ldic_pkg::NUM_CH-1:0]                                chan_enable,
    output logic [ldic_pkg::NUM_CH-1:0][ldic_pkg::LEVEL_W-1:0]         chan_level
);

    ldic_pkg::ldic_state_s q;
    ldic_pkg::ldic_state_s d;

    logic       scl_rise;
    logic       scl_fall;
    logic       start_cond;
    logic       stop_cond;
    logic       byte_done;
    logic       wr_fire;
    logic       cmd_fire;
    logic [7:0] rd_byte;

    // edge detection reads only the second sync stage and its delayed copy
    assign scl_rise   = q.scl_sync[1] && !q.scl_dly;
    assign scl_fall   = !q.scl_sync[1] && q.scl_dly;
    assign start_cond = q.scl_sync[1] && q.scl_dly && !q.sda_sync[1] && q.sda_dly;
    assign stop_cond  = q.scl_sync[1] && q.scl_dly && q.sda_sync[1] && !q.sda_dly;
    assign byte_done  = scl_fall && (q.bitcnt == ldic_pkg::BYTE_BITS);
    assign wr_fire    = byte_done && (q.st == ldic_pkg::ST_DATA);
    assign cmd_fire   = byte_done && (q.st == ldic_pkg::ST_CMD);

    // read mux; unmapped indices read as zero
    always_comb
    begin
        rd_byte = ldic_pkg::REG_RESET;
        if ((q.idx & ldic_pkg::IDX_BANK_MASK) == ldic_pkg::IDX_LEVEL_BASE)
            rd_byte = q.level[q.idx[2:0]];
        else if ((q.idx & ldic_pkg::IDX_BANK_MASK) == ldic_pkg::IDX_DUTY_BASE)
            rd_byte = q.duty[q.idx[2:0]];
        else if (q.idx == ldic_pkg::IDX_OUT_MASK)
            rd_byte = q.mask;
    end

    always_comb
    begin
        d = q;
        d.scl_sync = {q.scl_sync[0], scl_i};
        d.sda_sync = {q.sda_sync[0], sda_i};
        d.scl_dly  = q.scl_sync[1];
        d.sda_dly  = q.sda_sync[1];
        d.pwm_cnt  = q.pwm_cnt + 1'b1;

        // sample on rising clock in every receiving phase
        if (scl_rise)
        begin
            if (q.st == ldic_pkg::ST_ADDR || q.st == ldic_pkg::ST_CMD || q.st == ldic_pkg::ST_DATA)
            begin
                d.shift  = {q.shift[6:0], q.sda_sync[1]};
                d.bitcnt = q.bitcnt + ldic_pkg::BIT_ONE;
            end
            else if (q.st == ldic_pkg::ST_RACK)
                d.nack = q.sda_sync[1];
        end

        if (scl_fall)
        begin
            case (q.st)
                ldic_pkg::ST_IDLE:
                    d.sda_oe_n = 1'b1;
                ldic_pkg::ST_ADDR:
                begin
                    if (q.bitcnt == ldic_pkg::BYTE_BITS)
                    begin
                        if (q.shift[7:1] == ldic_pkg::DEV_ADDR)
                        begin
                            d.st       = ldic_pkg::ST_AACK;
                            d.rw       = q.shift[0];
                            d.sda_oe_n = 1'b0;
                        end
                        else
                            d.st = ldic_pkg::ST_IDLE;
                    end
                end
                ldic_pkg::ST_AACK:
                begin
                    d.bitcnt = ldic_pkg::BIT_ZERO;
                    if (q.rw)
                    begin
                        // index was set by a preceding write frame
                        d.st       = ldic_pkg::ST_READ;
                        d.shift    = {rd_byte[6:0], 1'b0};
                        d.sda_oe_n = rd_byte[7];
                        d.bitcnt   = ldic_pkg::BIT_ONE;
                    end
                    else
                    begin
                        d.st       = ldic_pkg::ST_CMD;
                        d.sda_oe_n = 1'b1;
                    end
                end
                ldic_pkg::ST_CMD:
                begin
                    if (q.bitcnt == ldic_pkg::BYTE_BITS)
                    begin
                        d.cmd      = q.shift[ldic_pkg::CMD_HI:ldic_pkg::CMD_LO];
                        d.idx      = q.shift[ldic_pkg::IDX_HI:0];
                        d.st       = ldic_pkg::ST_CACK;
                        d.sda_oe_n = 1'b0;
                        if (q.shift[ldic_pkg::CMD_HI:ldic_pkg::CMD_LO] == ldic_pkg::CMD_APPLY)
                            d.active = q.mask;
                    end
                end
                ldic_pkg::ST_CACK, ldic_pkg::ST_DACK:
                begin
                    d.st       = ldic_pkg::ST_DATA;
                    d.bitcnt   = ldic_pkg::BIT_ZERO;
                    d.sda_oe_n = 1'b1;
                end
                ldic_pkg::ST_DATA:
                begin
                    if (q.bitcnt == ldic_pkg::BYTE_BITS)
                    begin
                        d.st       = ldic_pkg::ST_DACK;
                        d.sda_oe_n = 1'b0;
                        case (q.cmd)
                            ldic_pkg::CMD_ALL_LEVEL:
                                for (int i = 0; i < ldic_pkg::NUM_CH; i++)
                                    d.level[i] = q.shift;
                            ldic_pkg::CMD_ALL_DUTY:
                                for (int i = 0; i < ldic_pkg::NUM_CH; i++)
                                    d.duty[i] = q.shift;
                            ldic_pkg::CMD_WRITE, ldic_pkg::CMD_WRITE_APPLY:
                            begin
                                // a mask written without apply stays pending
                                if ((q.idx & ldic_pkg::IDX_BANK_MASK) == ldic_pkg::IDX_LEVEL_BASE)
                                    d.level[q.idx[2:0]] = q.shift;
                                else if ((q.idx & ldic_pkg::IDX_BANK_MASK) == ldic_pkg::IDX_DUTY_BASE)
                                    d.duty[q.idx[2:0]] = q.shift;
                                else if (q.idx == ldic_pkg::IDX_OUT_MASK)
                                    d.mask = q.shift;
                                if (q.cmd == ldic_pkg::CMD_WRITE_APPLY)
                                begin
                                    if (q.idx == ldic_pkg::IDX_OUT_MASK)
                                        d.active = q.shift;
                                    else
                                        d.active = q.mask;
                                end
                            end
                            default:
                                d.cmd = q.cmd;
                        endcase
                    end
                end
                ldic_pkg::ST_READ:
                begin
                    if (q.bitcnt == ldic_pkg::BYTE_BITS)
                    begin
                        d.st       = ldic_pkg::ST_RACK;
                        d.sda_oe_n = 1'b1;
                    end
                    else
                    begin
                        d.sda_oe_n = q.shift[7];
                        d.shift    = {q.shift[6:0], 1'b0};
                        d.bitcnt   = q.bitcnt + ldic_pkg::BIT_ONE;
                    end
                end
                ldic_pkg::ST_RACK:
                begin
                    // an acknowledged byte is followed by the same register again
                    if (q.nack)
                    begin
                        d.st       = ldic_pkg::ST_IDLE;
                        d.sda_oe_n = 1'b1;
                    end
                    else
                    begin
                        d.st       = ldic_pkg::ST_READ;
                        d.shift    = {rd_byte[6:0], 1'b0};
                        d.sda_oe_n = rd_byte[7];
                        d.bitcnt   = ldic_pkg::BIT_ONE;
                    end
                end
                default:
                begin
                    d.st       = ldic_pkg::ST_IDLE;
                    d.sda_oe_n = 1'b1;
                end
            endcase
        end

        // start and stop override any phase, a repeated start included
        if (start_cond)
        begin
            d.st       = ldic_pkg::ST_ADDR;
            d.bitcnt   = ldic_pkg::BIT_ZERO;
            d.sda_oe_n = 1'b1;
        end
        else if (stop_cond)
        begin
            d.st       = ldic_pkg::ST_IDLE;
            d.sda_oe_n = 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            q          <= '0;
            q.scl_sync <= 2'h3;
            q.sda_sync <= 2'h3;
            q.scl_dly  <= 1'b1;
            q.sda_dly  <= 1'b1;
            q.sda_oe_n <= 1'b1;
        end
        else
            q <= d;
    end

    // open drain: the pad only ever pulls low
    assign sda_o       = q.rw & 1'b0;
    assign sda_oe_n    = q.sda_oe_n;
    assign chan_enable = q.active;

    genvar g;
    generate
        for (g = 0; g < ldic_pkg::NUM_CH; g++)
        begin : g_ch
            assign chan_level[g] = q.level[g][ldic_pkg::LEVEL_W-1:0];
            ldic_pwm u_pwm
            (
                .clk     (clk),
                .rst_n   (rst_n),
                .enable  (q.active[g]),
                .duty    (q.duty[g][ldic_pkg::DUTY_W-1:0]),
                .pwm_cnt (q.pwm_cnt),
                .drive   (chan_drive[g])
            );
        end
    endgenerate

    property p_addr_ack;
        @(posedge clk) disable iff (!rst_n)
        (q.st == ldic_pkg::ST_ADDR && byte_done && !start_cond && !stop_cond
         && q.shift[7:1] == ldic_pkg::DEV_ADDR) |=> (q.st == ldic_pkg::ST_AACK && !q.sda_oe_n);
    endproperty
    a_addr_ack: assert property (p_addr_ack)
        else $error("matching address not acknowledged");
    property p_addr_miss;
        @(posedge clk) disable iff (!rst_n)
        (q.st == ldic_pkg::ST_ADDR && byte_done && !start_cond
         && q.shift[7:1] != ldic_pkg::DEV_ADDR) |=> (q.sda_oe_n && q.st == ldic_pkg::ST_IDLE);
    endproperty
    a_addr_miss: assert property (p_addr_miss)
        else $error("foreign address acknowledged");
    property p_all_level;
        @(posedge clk) disable iff (!rst_n)
        (wr_fire && !start_cond && !stop_cond && q.cmd == ldic_pkg::CMD_ALL_LEVEL)
        |=> (q.level == {ldic_pkg::NUM_CH{$past(q.shift)}});
    endproperty
    a_all_level: assert property (p_all_level)
        else $error("broadcast level write missed a channel");
    property p_all_duty;
        @(posedge clk) disable iff (!rst_n)
        (wr_fire && !start_cond && !stop_cond && q.cmd == ldic_pkg::CMD_ALL_DUTY)
        |=> (q.duty == {ldic_pkg::NUM_CH{$past(q.shift)}});
    endproperty
    a_all_duty: assert property (p_all_duty)
        else $error("broadcast duty write missed a channel");
    property p_ch8_level;
        @(posedge clk) disable iff (!rst_n)
        (wr_fire && q.cmd == ldic_pkg::CMD_WRITE && q.idx == ldic_pkg::IDX_CH8_LEVEL)
        |=> (q.level[7] == $past(q.shift) && $stable(q.level[0]));
    endproperty
    a_ch8_level: assert property (p_ch8_level)
        else $error("single level write wrong");
    property p_mask_pending;
        @(posedge clk) disable iff (!rst_n)
        (wr_fire && q.cmd == ldic_pkg::CMD_WRITE && q.idx == ldic_pkg::IDX_OUT_MASK)
        |=> (q.mask == $past(q.shift) && $stable(q.active));
    endproperty
    a_mask_pending: assert property (p_mask_pending)
        else $error("pending mask took effect early");
    property p_mask_apply;
        @(posedge clk) disable iff (!rst_n)
        (wr_fire && q.cmd == ldic_pkg::CMD_WRITE_APPLY && q.idx == ldic_pkg::IDX_OUT_MASK)
        |=> (q.active == $past(q.shift));
    endproperty
    a_mask_apply: assert property (p_mask_apply)
        else $error("write with apply did not update outputs");
    property p_apply_cmd;
        @(posedge clk) disable iff (!rst_n)
        (cmd_fire && q.shift[ldic_pkg::CMD_HI:ldic_pkg::CMD_LO] == ldic_pkg::CMD_APPLY)
        |=> (q.active == $past(q.mask)) ##1 (chan_enable == $past(q.mask, 2));
    endproperty
    a_apply_cmd: assert property (p_apply_cmd)
        else $error("apply command did not take pending mask");
    property p_duty_read;
        @(posedge clk) disable iff (!rst_n)
        (q.st == ldic_pkg::ST_AACK && scl_fall && !start_cond && !stop_cond && q.rw
         && q.idx == ldic_pkg::IDX_CH1_DUTY)
        |=> (q.st == ldic_pkg::ST_READ && q.sda_oe_n == $past(q.duty[0][7]));
    endproperty
    a_duty_read: assert property (p_duty_read)
        else $error("read of channel one duty drove wrong bit");
    property p_chan_off;
        @(posedge clk) disable iff (!rst_n)
        (!q.active[7] && !q.active[0]) |=> (!chan_drive[7] && !chan_drive[0]);
    endproperty
    a_chan_off: assert property (p_chan_off)
        else $error("disabled channel driven");

endmodule // ldic_i2c_port

// ==== ldic_pkg.sv ====
package ldic_pkg;

    // bus address and frame layout
    localparam logic [6:0] DEV_ADDR       = 7'h1b;
    localparam logic [3:0] BYTE_BITS      = 4'h8;
    localparam logic [3:0] BIT_ONE        = 4'h1;
    localparam logic [3:0] BIT_ZERO       = 4'h0;
    localparam int         CMD_HI         = 7;
    localparam int         CMD_LO         = 5;
    localparam int         IDX_HI         = 4;

    // command field codes
    localparam logic [2:0] CMD_APPLY      = 3'h0;
    localparam logic [2:0] CMD_WRITE      = 3'h1;
    localparam logic [2:0] CMD_WRITE_APPLY = 3'h2;
    localparam logic [2:0] CMD_ALL_LEVEL  = 3'h3;
    localparam logic [2:0] CMD_ALL_DUTY   = 3'h4;

    // register indices
    localparam logic [4:0] IDX_LEVEL_BASE = 5'h00;
    localparam logic [4:0] IDX_CH8_LEVEL  = 5'h07;
    localparam logic [4:0] IDX_DUTY_BASE  = 5'h08;
    localparam logic [4:0] IDX_CH1_DUTY   = 5'h08;
    localparam logic [4:0] IDX_OUT_MASK   = 5'h10;
    localparam logic [4:0] IDX_BANK_MASK  = 5'h18;
    localparam logic [2:0] IDX_CH_MASK    = 3'h7;

    // widths and reset values
    localparam int         NUM_CH         = 8;
    localparam int         LEVEL_W        = 5;
    localparam int         DUTY_W         = 6;
    localparam logic [7:0] REG_RESET      = 8'h00;
    localparam logic [5:0] HALF_DUTY      = 6'h20;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0000,
        ST_ADDR = 4'b0001,
        ST_AACK = 4'b0010,
        ST_CMD  = 4'b0011,
        ST_CACK = 4'b0100,
        ST_DATA = 4'b0101,
        ST_DACK = 4'b0110,
        ST_READ = 4'b0111,
        ST_RACK = 4'b1000
    } ldic_state_e;

    typedef struct packed {
        ldic_state_e                  st;
        logic [1:0]                   scl_sync;
        logic [1:0]                   sda_sync;
        logic                         scl_dly;
        logic                         sda_dly;
        logic [7:0]                   shift;
        logic [3:0]                   bitcnt;
        logic                         rw;
        logic                         nack;
        logic [2:0]                   cmd;
        logic [4:0]                   idx;
        logic [NUM_CH-1:0][7:0]       level;
        logic [NUM_CH-1:0][7:0]       duty;
        logic [7:0]                   mask;
        logic [7:0]                   active;
        logic                         sda_oe_n;
        logic [DUTY_W-1:0]            pwm_cnt;
    } ldic_state_s;

    typedef struct packed {
        logic drive;
    } ldic_pwm_s;

endpackage

// ==== ldic_pwm.sv ====
`timescale 1ns/1ps
module ldic_pwm
(
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        rst_n,
    // channel settings
    input  wire logic                        enable,
    input  wire logic [ldic_pkg::DUTY_W-1:0] duty,
    input  wire logic [ldic_pkg::DUTY_W-1:0] pwm_cnt,
    // channel output
    output logic                             drive
);

    ldic_pkg::ldic_pwm_s q;
    ldic_pkg::ldic_pwm_s d;

    // a 64-step period makes a duty of half the range exactly half on
    always_comb
    begin
        d       = q;
        d.drive = enable && (pwm_cnt < duty);
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            q <= '0;
        else
            q <= d;
    end

    assign drive = q.drive;

endmodule // ldic_pwm

// ==== tb_led_driver_i2c_command_port.sv ====
`timescale 1ns/1ps
module tb_led_driver_i2c_command_port;
    localparam int CEILING = 50000;
    logic                                               clk;
    logic                                               rst_n;
    logic                                               scl;
    logic                                               sda_low;
    logic                                               sda_line;
    logic                                               sda_o;
    logic                                               sda_oe_n;
    logic [ldic_pkg::NUM_CH-1:0]                        chan_drive;
    logic [ldic_pkg::NUM_CH-1:0]                        chan_enable;
    logic [ldic_pkg::NUM_CH-1:0][ldic_pkg::LEVEL_W-1:0] chan_level;
    int                                                 fail_count = 0;
    int                                                 checks_done = 0;
    int                                                 cycles = 0;

    // pull-up wins when nobody pulls low
    assign sda_line = sda_low ? 1'b0 : (sda_oe_n ? 1'b1 : sda_o);

    ldic_i2c_port dut (.clk(clk), .rst_n(rst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
                       .sda_oe_n(sda_oe_n), .chan_drive(chan_drive), .chan_enable(chan_enable),
                       .chan_level(chan_level));
    ldic_bus_master m (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));

    task automatic final_report();
        if (fail_count == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask

    task automatic write_frame(input logic [2:0] cmd, input logic [4:0] idx, input logic [7:0] data,
                               input bit with_data);
        logic a0, a1, a2;
        a2 = 1'b1;
        m.start_cond();
        m.send_byte({ldic_pkg::DEV_ADDR, 1'b0}, a0);
        m.send_byte({cmd, idx}, a1);
        if (with_data)
            m.send_byte(data, a2);
        m.stop_cond();
        check("write acks", 40'h7, 40'({a0, a1, a2}));
    endtask

    task automatic read_check(input logic [4:0] idx, input logic [7:0] exp);
        logic       a0, a1, a2;
        logic [7:0] val;
        m.start_cond();
        m.send_byte({ldic_pkg::DEV_ADDR, 1'b0}, a0);
        m.send_byte({ldic_pkg::CMD_WRITE, idx}, a1);
        m.start_cond();
        m.send_byte({ldic_pkg::DEV_ADDR, 1'b1}, a2);
        m.recv_byte(1'b0, val);
        m.stop_cond();
        check("read acks", 40'h7, 40'({a0, a1, a2}));
        check("read data", 40'(exp), 40'(val));
    endtask

    task automatic t_reset_values();
        check("sda_oe_n", 40'h1, 40'(sda_oe_n));
        check("sda_o", 40'h0, 40'(sda_o));
        check("chan_enable", 40'h0, 40'(chan_enable));
        check("chan_level", 40'h0, 40'(chan_level));
        read_check(ldic_pkg::IDX_CH8_LEVEL, 8'h00);
        read_check(ldic_pkg::IDX_CH1_DUTY, 8'h00);
        read_check(ldic_pkg::IDX_OUT_MASK, 8'h00);
    endtask

    task automatic t_bad_address();
        logic a;
        m.start_cond();
        m.send_byte({7'h1c, 1'b0}, a);
        m.stop_cond();
        check("foreign address ack", 40'h0, 40'(a));
    endtask

    task automatic t_levels();
        write_frame(ldic_pkg::CMD_ALL_LEVEL, 5'h1f, 8'h05, 1'b1);
        check("chan_level all", 40'({8{5'h05}}), 40'(chan_level));
        write_frame(ldic_pkg::CMD_WRITE, ldic_pkg::IDX_CH8_LEVEL, 8'h0b, 1'b1);
        check("chan_level ch8", 40'({5'h0b, {7{5'h05}}}), 40'(chan_level));
        read_check(ldic_pkg::IDX_CH8_LEVEL, 8'h0b);
        read_check(5'h00, 8'h05);
    endtask

    task automatic t_duties();
        // index 0 is a level register; the broadcast must leave it alone
        write_frame(ldic_pkg::CMD_ALL_DUTY, 5'h00, 8'h20, 1'b1);
        check("chan_level kept", 40'({5'h0b, {7{5'h05}}}), 40'(chan_level));
        read_check(ldic_pkg::IDX_CH1_DUTY, 8'h20);
        read_check(5'h0f, 8'h20);
    endtask

    task automatic t_outputs();
        write_frame(ldic_pkg::CMD_WRITE_APPLY, ldic_pkg::IDX_OUT_MASK, 8'h8f, 1'b1);
        check("chan_enable applied", 40'h8f, 40'(chan_enable));
        write_frame(ldic_pkg::CMD_WRITE, ldic_pkg::IDX_OUT_MASK, 8'h0f, 1'b1);
        check("chan_enable held", 40'h8f, 40'(chan_enable));
        read_check(ldic_pkg::IDX_OUT_MASK, 8'h0f);
        write_frame(ldic_pkg::CMD_APPLY, 5'h15, 8'h00, 1'b0);
        check("chan_enable on apply", 40'h0f, 40'(chan_enable));
        write_frame(ldic_pkg::CMD_WRITE, ldic_pkg::IDX_OUT_MASK, 8'h01, 1'b1);
        write_frame(ldic_pkg::CMD_WRITE_APPLY, ldic_pkg::IDX_CH1_DUTY, 8'h20, 1'b1);
        check("chan_enable pending", 40'h01, 40'(chan_enable));
        // an undefined command is acknowledged but must not touch any register
        write_frame(3'h5, ldic_pkg::IDX_OUT_MASK, 8'hff, 1'b1);
        read_check(ldic_pkg::IDX_OUT_MASK, 8'h01);
        check("chan_enable after undefined command", 40'h01, 40'(chan_enable));
    endtask

    task automatic t_pwm();
        int hi [ldic_pkg::NUM_CH];
        write_frame(ldic_pkg::CMD_WRITE_APPLY, ldic_pkg::IDX_OUT_MASK, 8'h8f, 1'b1);
        foreach (hi[c])
            hi[c] = 0;
        // one full 64-clk period
        repeat (64)
        begin
            m.wait_clk(1);
            foreach (hi[c])
                hi[c] += int'(chan_drive[c]);
        end
        foreach (hi[c])
            check("pwm high cycles", 40'((8'h8f >> c) & 1 ? 32 : 0), 40'(hi[c]));
    endtask

    task automatic t_second_reset();
        rst_n = 1'b0;
        m.wait_clk(3);
        rst_n = 1'b1;
        m.wait_clk(4);
        check("chan_enable after reset", 40'h0, 40'(chan_enable));
        check("chan_level after reset", 40'h0, 40'(chan_level));
        read_check(ldic_pkg::IDX_CH1_DUTY, 8'h00);
    endtask

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    initial
    begin
        rst_n = 1'b0;
        repeat (3) @(posedge clk);
        #1;
        rst_n = 1'b1;
        m.wait_clk(4);
        t_reset_values();
        t_bad_address();
        t_levels();
        t_duties();
        t_outputs();
        t_pwm();
        t_second_reset();
        final_report();
    end

    // hang guard, well above the roughly 16 thousand clk the run needs
    always @(posedge clk)
    begin
        cycles <= cycles + 1;
        if (cycles == CEILING)
        begin
            fail_count++;
            final_report();
        end
    end
endmodule // tb_led_driver_i2c_command_port
